// [pkg/cmp_ctrl_pkg.sv]
package cmp_ctrl_pkg;
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] FLAG_OFFSET     = 12'h004;
  localparam logic [7:0]  CTRL_RESET      = 8'h07;
  localparam logic [2:0]  FLAG_RESET      = 3'h0;
  localparam int          RESULT_B_BIT    = 7;
  localparam int          RESULT_A_BIT    = 6;
  localparam int          INVERT_B_BIT    = 5;
  localparam int          INVERT_A_BIT    = 4;
  localparam int          SWITCH_BIT      = 3;
  localparam int          FLAG_BIT        = 0;
  localparam int          IRQ_EN_BIT      = 1;
  localparam int          VALID_BIT       = 2;
  localparam logic [2:0]  MODE_MUX4       = 3'h6;
  localparam logic [2:0]  MODE_OFF        = 3'h7;
  localparam int          SETTLE_NS       = 10000;
  localparam int          CLK_NS          = 25;
  localparam int          SETTLE_CYCLES   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0]  SETTLE_COUNT    = 9'(SETTLE_CYCLES);
  typedef enum logic [1:0] {IDLE, ACCESS} apb_state_e;
endpackage

// [verilog/cmp_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for one raw comparator level
module cmp_sync
  import cmp_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic rawIn,
  output logic      syncOut
);
  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  // First stage feeds only the second
  always_comb begin
    next_stage1  = rawIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule

// [verilog/cmp_route.sv]
`timescale 1ns/1ps
// Mode-dependent input routing selects for the analog pair
module cmp_route
  import cmp_ctrl_pkg::*;
(
  input  wire logic [2:0] mode,
  input  wire logic       inSwitch,
  output logic [1:0]      selNegA,
  output logic [1:0]      selNegB,
  output logic            refToPos,
  output logic [1:0]      enable
);
  // Select codes: analog input index feeding each inverting input
  always_comb begin
    refToPos = (mode == MODE_MUX4);
    enable   = (mode == MODE_OFF) ? 2'h0 : 2'h3;
    selNegA  = 2'h0;
    selNegB  = 2'h1;
    if (mode == MODE_MUX4 && inSwitch) begin
      selNegA = 2'h3;
      selNegB = 2'h2;
    end else if (mode == MODE_MUX4) begin
      selNegA = 2'h0;
      selNegB = 2'h1;
    end
  end
endmodule

// [verilog/dual_comparator_control.sv]
`timescale 1ns/1ps
// Comparator pair control: APB registers, result sync, change flag
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        cmpARaw,
  input  wire logic        cmpBRaw,
  input  wire logic [1:0]  portADirection,
  output logic [2:0]       comparatorModeSel,
  output logic [1:0]       cmpNegSelA,
  output logic [1:0]       cmpNegSelB,
  output logic             cmpRefToPos,
  output logic [1:0]       cmpEnable,
  output logic [1:0]       pinOut,
  output logic [1:0]       pinOutEn_n,
  output logic             comparatorChangeFlag,
  output logic             comparatorChangeIrq,
  output logic             outputsValid
);
  // Control fields
  logic       cmpBInvert;
  logic       cmpAInvert;
  logic       invertingInputSwitch;
  logic       next_cmpBInvert;
  logic       next_cmpAInvert;
  logic       next_invertingInputSwitch;
  logic [2:0] next_comparatorModeSel;
  logic       irqEn;
  logic       next_irqEn;
  // Sync and mismatch state
  logic       syncA;
  logic       syncB;
  logic [1:0] lastSeen;
  logic [1:0] next_lastSeen;
  logic       next_comparatorChangeFlag;
  logic       next_comparatorChangeIrq;
  logic [8:0] settleCnt;
  logic [8:0] next_settleCnt;
  logic       next_outputsValid;
  // Routing and pins
  logic [1:0] selNegA;
  logic [1:0] selNegB;
  logic       refToPos;
  logic [1:0] enable;
  logic [1:0] next_cmpNegSelA;
  logic [1:0] next_cmpNegSelB;
  logic       next_cmpRefToPos;
  logic [1:0] next_cmpEnable;
  logic [1:0] next_pinOut;
  logic [1:0] next_pinOutEn_n;
  // Bus
  apb_state_e apbState;
  apb_state_e next_apbState;
  logic       next_pready;
  logic [31:0] next_prdata;
  logic       next_pslverr;
  logic       accessDone;
  logic       ctrlHit;
  logic       flagHit;
  logic [1:0] resultBits;
  logic [1:0] mismatch;

  // Apply inversion; used for register bits and pins alike
  function automatic logic [1:0] polarity(input logic [1:0] raw,
                                          input logic invB,
                                          input logic invA);
    polarity = {raw[1] ^ invB, raw[0] ^ invA};
  endfunction

  // Raw outputs are set high/low by the analog parts; sync only
  cmp_sync u_sync_a (
    .clk     (clk),
    .rst_n   (rst_n),
    .rawIn   (cmpARaw),
    .syncOut (syncA)
  );

  cmp_sync u_sync_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .rawIn   (cmpBRaw),
    .syncOut (syncB)
  );

  cmp_route u_route (
    .mode     (comparatorModeSel),
    .inSwitch (invertingInputSwitch),
    .selNegA  (selNegA),
    .selNegB  (selNegB),
    .refToPos (refToPos),
    .enable   (enable)
  );

  // Result bits from synced values, never from written data
  assign resultBits = polarity({syncB, syncA}, cmpBInvert,
                               cmpAInvert);
  assign mismatch   = resultBits ^ lastSeen;
  assign accessDone = (apbState == ACCESS) && psel && penable;
  assign ctrlHit    = (paddr == CTRL_OFFSET);
  assign flagHit    = (paddr == FLAG_OFFSET);

  // APB slave: no wait states, answer in access cycle after setup
  always_comb begin
    next_apbState = apbState;
    next_pready   = 1'b0;
    next_prdata   = prdata;
    next_pslverr  = 1'b0;
    case (apbState)
      IDLE: begin
        if (psel && !penable) begin
          next_apbState = ACCESS;
          next_pready   = 1'b1;
          next_pslverr  = !(ctrlHit || flagHit);
          next_prdata   = 32'h0000_0000;
          if (ctrlHit) begin
            next_prdata[7:0] = {resultBits, cmpBInvert, cmpAInvert,
                                invertingInputSwitch, comparatorModeSel};
          end else if (flagHit) begin
            next_prdata[2:0] = {outputsValid, irqEn,
                                comparatorChangeFlag};
          end
        end
      end
      ACCESS: begin
        next_apbState = IDLE;
      end
      default: begin
        next_apbState = IDLE;
      end
    endcase
  end

  // Control and flag register writes; mode field steers routing
  always_comb begin
    next_cmpBInvert           = cmpBInvert;
    next_cmpAInvert           = cmpAInvert;
    next_invertingInputSwitch = invertingInputSwitch;
    next_comparatorModeSel    = comparatorModeSel;
    next_irqEn                = irqEn;
    if (accessDone && pwrite && ctrlHit) begin
      next_cmpBInvert           = pwdata[INVERT_B_BIT];
      next_cmpAInvert           = pwdata[INVERT_A_BIT];
      next_invertingInputSwitch = pwdata[SWITCH_BIT];
      next_comparatorModeSel    = pwdata[2:0];
    end
    if (accessDone && pwrite && flagHit) begin
      next_irqEn = pwdata[IRQ_EN_BIT];
    end
  end

  // Mismatch latch and change flag; set beats clear
  always_comb begin
    next_lastSeen             = lastSeen;
    next_comparatorChangeFlag = comparatorChangeFlag;
    if (accessDone && ctrlHit) begin
      next_lastSeen = resultBits;
    end
    if (accessDone && pwrite && flagHit &&
        !pwdata[FLAG_BIT]) begin
      next_comparatorChangeFlag = 1'b0;
    end
    if (accessDone && pwrite && flagHit && pwdata[FLAG_BIT]) begin
      next_comparatorChangeFlag = 1'b1; // software-raised event
    end
    if (mismatch != 2'h0) begin
      next_comparatorChangeFlag = 1'b1;
    end
    next_comparatorChangeIrq = next_comparatorChangeFlag && next_irqEn;
  end

  // Settling window after a mode change; a false change is possible
  always_comb begin
    next_settleCnt = settleCnt;
    if (next_comparatorModeSel != comparatorModeSel) begin
      next_settleCnt = SETTLE_COUNT;
    end else if (settleCnt != 9'h000) begin
      next_settleCnt = settleCnt - 9'h001;
    end
    next_outputsValid = (next_settleCnt == 9'h000) &&
                        (next_comparatorModeSel != MODE_OFF);
  end

  // Registered analog controls and pin drivers
  always_comb begin
    next_cmpNegSelA  = selNegA;
    next_cmpNegSelB  = selNegB;
    next_cmpRefToPos = refToPos;
    next_cmpEnable   = enable;
    next_pinOut      = resultBits;
    next_pinOutEn_n  = portADirection;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmpBInvert           <= CTRL_RESET[INVERT_B_BIT];
      cmpAInvert           <= CTRL_RESET[INVERT_A_BIT];
      invertingInputSwitch <= CTRL_RESET[SWITCH_BIT];
      comparatorModeSel    <= CTRL_RESET[2:0];
      irqEn                <= FLAG_RESET[IRQ_EN_BIT];
      lastSeen             <= 2'h0;
      comparatorChangeFlag <= FLAG_RESET[FLAG_BIT];
      comparatorChangeIrq  <= 1'b0;
      settleCnt            <= 9'h000;
      outputsValid         <= 1'b0;
      apbState             <= IDLE;
      pready               <= 1'b0;
      prdata               <= 32'h0000_0000;
      pslverr              <= 1'b0;
      cmpNegSelA           <= 2'h0;
      cmpNegSelB           <= 2'h1;
      cmpRefToPos          <= 1'b0;
      cmpEnable            <= 2'h0;
      pinOut               <= 2'h0;
      pinOutEn_n           <= 2'h3;
    end else begin
      cmpBInvert           <= next_cmpBInvert;
      cmpAInvert           <= next_cmpAInvert;
      invertingInputSwitch <= next_invertingInputSwitch;
      comparatorModeSel    <= next_comparatorModeSel;
      irqEn                <= next_irqEn;
      lastSeen             <= next_lastSeen;
      comparatorChangeFlag <= next_comparatorChangeFlag;
      comparatorChangeIrq  <= next_comparatorChangeIrq;
      settleCnt            <= next_settleCnt;
      outputsValid         <= next_outputsValid;
      apbState             <= next_apbState;
      pready               <= next_pready;
      prdata               <= next_prdata;
      pslverr              <= next_pslverr;
      cmpNegSelA           <= next_cmpNegSelA;
      cmpNegSelB           <= next_cmpNegSelB;
      cmpRefToPos          <= next_cmpRefToPos;
      cmpEnable            <= next_cmpEnable;
      pinOut               <= next_pinOut;
      pinOutEn_n           <= next_pinOutEn_n;
    end
  end
endmodule

// [dv/cmp_analog_model.sv]
`timescale 1ns/1ps
// Behavioural pair of analog comparators on the far side of the block
module cmp_analog_model (
  input  wire logic [4:0][7:0] lvl,
  input  wire logic [7:0]      posA,
  input  wire logic [7:0]      posB,
  input  wire logic [1:0]      negSelA,
  input  wire logic [1:0]      negSelB,
  input  wire logic            refToPos,
  input  wire logic [1:0]      enable,
  output logic                 rawA,
  output logic                 rawB
);
  logic [7:0] plusA;
  logic [7:0] plusB;
  // Reference replaces both plus inputs only when routed there
  assign plusA = refToPos ? lvl[4] : posA;
  assign plusB = refToPos ? lvl[4] : posB;
  // Off comparators sit low; equal levels resolve low, never unknown
  assign rawA = enable[0] && (plusA > lvl[negSelA]);
  assign rawB = enable[1] && (plusB > lvl[negSelB]);
endmodule

// [dv/dual_comparator_control_props.sv]
`timescale 1ns/1ps
// Port-level checks for the comparator control block
module dual_comparator_control_props
  import cmp_ctrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  portADirection,
  input wire logic [2:0]  comparatorModeSel,
  input wire logic        cmpRefToPos,
  input wire logic [1:0]  cmpEnable,
  input wire logic [1:0]  pinOutEn_n,
  input wire logic        comparatorChangeFlag,
  input wire logic        outputsValid
);
  logic wrCtrl;
  logic wrFlag;
  // Completed writes, decoded once for several properties
  assign wrCtrl = psel && penable && pready && pwrite && paddr == CTRL_OFFSET;
  assign wrFlag = psel && penable && pready && pwrite && paddr == FLAG_OFFSET;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready || $past(psel && !penable))
    else $error("ready held too long");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  reset_mode_off_a: assert property ($rose(rst_n) |->
    comparatorModeSel == MODE_OFF && cmpEnable == 2'b00)
    else $error("reset mode not off");
  mode_write_a: assert property (wrCtrl |=>
    comparatorModeSel == $past(pwdata[2:0])) else $error("mode not written");
  // Analog controls are registered from the mode, so they trail it by a cycle
  ref_only_mux4_a: assert property (
    cmpRefToPos == $past(comparatorModeSel == MODE_MUX4))
    else $error("ref route");
  enable_by_mode_a: assert property (
    cmpEnable == ($past(comparatorModeSel == MODE_OFF) ? 2'b00 : 2'b11))
    else $error("enable vs mode");
  pin_dir_copy_a: assert property (
    rst_n |=> pinOutEn_n == $past(portADirection)) else $error("pin dir");
  flag_sticky_a: assert property (
    comparatorChangeFlag && !wrFlag |=> comparatorChangeFlag)
    else $error("flag dropped");
  settle_restart_a: assert property (
    wrCtrl && pwdata[2:0] != comparatorModeSel |=> !outputsValid)
    else $error("valid during settling");
  cover property (wrCtrl && pwdata[2:0] == MODE_MUX4);
  cover property ($rose(comparatorChangeFlag));
  cover property (pslverr);
endmodule

bind dual_comparator_control dual_comparator_control_props
  dual_comparator_control_props_i (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .portADirection(portADirection),
  .comparatorModeSel(comparatorModeSel), .cmpRefToPos(cmpRefToPos),
  .cmpEnable(cmpEnable), .pinOutEn_n(pinOutEn_n),
  .comparatorChangeFlag(comparatorChangeFlag), .outputsValid(outputsValid));

// [dv/tb.sv]
`timescale 1ns/1ps
// Register-side bench for the comparator control block
module tb
  import cmp_ctrl_pkg::*;
;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
    logic [1:0] nA;
    logic [1:0] nB;
    logic       toRef;
    logic [1:0] en;
  } row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic cmpARaw, cmpBRaw, cmpRefToPos, comparatorChangeFlag;
  logic comparatorChangeIrq, outputsValid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] comparatorModeSel;
  logic [1:0] portADirection, cmpNegSelA, cmpNegSelB, cmpEnable;
  logic [1:0] pinOut, pinOutEn_n;
  logic [4:0][7:0] lvl;
  logic [7:0] posA, posB;
  int n_errors, n_checks;
  // Levels: inputs 0..3 = 10,20,30,40, reference 25, plus A 35, plus B 15
  row_s rows [11] = '{
    '{8'h06, 8'hC6, 2'h0, 2'h1, 1'b1, 2'h3}, '{8'h0E, 8'h0E, 2'h3, 2'h2, 1'b1, 2'h3},
    '{8'h36, 8'h36, 2'h0, 2'h1, 1'b1, 2'h3}, '{8'h3E, 8'hFE, 2'h3, 2'h2, 1'b1, 2'h3},
    '{8'h01, 8'h41, 2'h0, 2'h1, 1'b0, 2'h3}, '{8'h12, 8'h12, 2'h0, 2'h1, 1'b0, 2'h3},
    '{8'h23, 8'hE3, 2'h0, 2'h1, 1'b0, 2'h3}, '{8'hC4, 8'h44, 2'h0, 2'h1, 1'b0, 2'h3},
    '{8'h00, 8'h40, 2'h0, 2'h1, 1'b0, 2'h3}, '{8'h05, 8'h45, 2'h0, 2'h1, 1'b0, 2'h3},
    '{8'h0F, 8'h0F, 2'h0, 2'h1, 1'b0, 2'h0}};

  dual_comparator_control dual_comparator_control_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmpARaw(cmpARaw), .cmpBRaw(cmpBRaw), .portADirection(portADirection),
    .comparatorModeSel(comparatorModeSel), .cmpNegSelA(cmpNegSelA),
    .cmpNegSelB(cmpNegSelB), .cmpRefToPos(cmpRefToPos), .cmpEnable(cmpEnable),
    .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .outputsValid(outputsValid),
    .comparatorChangeFlag(comparatorChangeFlag),
    .comparatorChangeIrq(comparatorChangeIrq));
  cmp_analog_model cmp_analog_model_i (.lvl(lvl), .posA(posA), .posB(posB),
    .negSelA(cmpNegSelA), .negSelB(cmpNegSelB), .refToPos(cmpRefToPos),
    .enable(cmpEnable), .rawA(cmpARaw), .rawB(cmpBRaw));

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  // One APB transfer; an idle edge follows so callers may chain freely
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1); // Watchdog bounds the wait
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [35:0] g, input logic [35:0] x,
                     input string m);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected 5100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata, portADirection} = '0;
    rst_n = 1'b0;
    lvl = {8'h19, 8'h28, 8'h1E, 8'h14, 8'h0A};
    posA = 8'h23;
    posB = 8'h0F;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Table of modes, polarities and routing, waiting out the settle time
    for (int i = 0; i < 11; i++) begin
      portADirection <= 2'(i);
      apb(1'b1, CTRL_OFFSET, {24'h0, rows[i].wr});
      repeat (SETTLE_CYCLES + 10) @(posedge clk);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(36'(r), 36'({24'h0, rows[i].rd}), "control");
      chk({cmpNegSelA, cmpNegSelB, cmpRefToPos, cmpEnable, pinOut, pinOutEn_n,
        outputsValid}, {rows[i].nA, rows[i].nB, rows[i].toRef, rows[i].en,
        rows[i].rd[7:6], 2'(i), rows[i].wr[2:0] != 3'h7}, "ports");
    end
    $display("table done");
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk({r, comparatorModeSel}, {CTRL_RESET, 3'h7}, "reset");
    $display("reset done");
    apb(1'b0, 12'h008, 32'h0);
    chk({e, r}, {1'b1, 32'h0}, "unmapped");
    $display("unmapped done");
    // Change flag: mismatch holds the flag until the control register is touched
    apb(1'b1, CTRL_OFFSET, 32'h01);
    repeat (SETTLE_CYCLES + 10) @(posedge clk);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    apb(1'b1, FLAG_OFFSET, 32'h2);
    chk(comparatorChangeFlag, 1'b0, "flag clear");
    posA <= 8'h05;
    repeat (8) @(posedge clk);
    chk({comparatorChangeFlag, comparatorChangeIrq}, 2'b11, "flag set");
    apb(1'b1, FLAG_OFFSET, 32'h2);
    repeat (3) @(posedge clk);
    chk(comparatorChangeFlag, 1'b1, "mismatch holds");
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(r, 32'h01, "result low");
    apb(1'b1, FLAG_OFFSET, 32'h2);
    repeat (3) @(posedge clk);
    chk({comparatorChangeFlag, comparatorChangeIrq}, 2'b00, "cleared");
    apb(1'b1, FLAG_OFFSET, 32'h3);
    chk(comparatorChangeFlag, 1'b1, "software set");
    $display("flag done");
    // Change interrupt off before a mode change, as software should
    apb(1'b1, FLAG_OFFSET, 32'h0);
    chk(comparatorChangeIrq, 1'b0, "irq off");
    apb(1'b1, CTRL_OFFSET, 32'h02);
    chk(outputsValid, 1'b0, "settling");
    $display("settle done");
    results();
  end
endmodule
